// *** design/sro_pkg.sv ***
// Purpose: shared constants for the suspend/resume and otp command logic
// Assumes: extended spi, 3-byte addresses, one bit per serial clock
// Notes:   command codes are plain defaults, override here if needed
package sro_pkg;
    // command codes
    localparam logic [7:0] OP_WREN   = 8'h06;
    localparam logic [7:0] OP_RDSR   = 8'h05;
    localparam logic [7:0] OP_RDFSR  = 8'h70;
    localparam logic [7:0] OP_RESUME = 8'h7a;
    localparam logic [7:0] OP_RD_OTP = 8'h4b;
    localparam logic [7:0] OP_PG_OTP = 8'h42;
    // frame bit counts, counted in rising serial clock edges
    localparam logic [9:0] OPC_END   = 10'h008;
    localparam logic [9:0] ADDR_END  = 10'h020;
    localparam logic [9:0] RD_DATA   = 10'h028;
    localparam logic [9:0] CNT_MAX   = 10'h3ff;
    // otp area geometry
    localparam logic [6:0] OTP_LAST  = 7'h40;
    localparam logic [6:0] OTP_LATCH = 7'h41;
    localparam logic [7:0] OTP_ERASED = 8'hff;
    localparam int         LOCK_BIT  = 0;
    // array address fields
    localparam int         SECT_LSB  = 16;
    localparam int         PAGE_LSB  = 8;
    // status and flag status fields and reset values
    localparam int         SR_WIP    = 0;
    localparam int         SR_WEL    = 1;
    localparam int         FSR_PROT  = 1;
    localparam int         FSR_PSUS  = 2;
    localparam int         FSR_PFAIL = 4;
    localparam int         FSR_ESUS  = 6;
    localparam int         FSR_PEC   = 7;
    localparam logic [7:0] SR_RST    = 8'h00;
    localparam logic [7:0] FSR_RST   = 8'h80;
    // system clock rate
    localparam int         CLK_MHZ   = 100;
    // controller states, gray along idle-resumed-otp
    typedef enum logic [1:0] {
        SRO_IDLE    = 2'b00,
        SRO_RESUMED = 2'b01,
        SRO_OTP     = 2'b11
    } sro_state_t;
endpackage : sro_pkg

// *** design/sro_ctrl.sv ***
// Purpose: resume handling, suspend access limits and otp read/program
// Assumes: host keeps chip select high for more than five system clocks
// Notes:   serial logic runs on sclk_in, status logic on clock_in
`timescale 1ns/10ps
`default_nettype none
module sro_ctrl #(
    parameter int OTP_PROG_TIME_US = 2000   // otp program time in us
) (
    input  wire logic        clock_in,               // system clock
    input  wire logic        rst_n_in,               // sync reset, low
    input  wire logic        sclk_in,                // host serial clock
    input  wire logic        cs_n_in,                // chip select, low
    input  wire logic        serial_in_line_in,      // host to device
    output logic             serial_out_line_out,    // device to host
    output logic             serial_out_line_oe_out, // drive enable
    input  wire logic        pgm_suspend_in,         // program suspended
    input  wire logic        ers_suspend_in,         // erase suspended
    input  wire logic [25:0] suspend_addr_in,        // suspended address
    input  wire logic        op_done_in,             // resumed op done
    output logic             resume_pgm_out,         // resume program
    output logic             resume_ers_out,         // resume erase
    input  wire logic        chk_read_in,            // array read check
    input  wire logic        chk_prog_in,            // array prog check
    input  wire logic [25:0] chk_addr_in,            // checked address
    output logic             read_undef_out,         // read undefined
    output logic             prog_block_out,         // program refused
    input  wire logic        otp_stuck_in,           // otp cell timeout
    output logic [7:0]       status_out,             // status register
    output logic [7:0]       flag_status_out         // flag status
);
    localparam int PROG_CYC = OTP_PROG_TIME_US * sro_pkg::CLK_MHZ;
    localparam logic [23:0] PROG_LOAD =
        (PROG_CYC > 1) ? 24'(PROG_CYC - 1) : 24'h000000;

    // address of byte off within the otp area, 0xff when a is above 0x7f
    function automatic logic [7:0] loc_sum(input logic [23:0] a,
                                           input logic [6:0]  off);
        if (a[23:7] != 17'h00000)
            return 8'hff;
        return {1'b0, a[6:0]} + {1'b0, off};
    endfunction : loc_sum

    // true when two array addresses share a sector
    function automatic logic same_sect(input logic [25:0] a,
                                       input logic [25:0] b);
        return a[25:sro_pkg::SECT_LSB] == b[25:sro_pkg::SECT_LSB];
    endfunction : same_sect

    logic [7:0]  otp_mem [0:64];     // otp array plus control byte
    logic [7:0]  buf_r   [0:64];     // latched program bytes
    logic        start_r;            // no serial edge yet in frame
    logic        tog_r;              // flips once per clocked frame
    logic        lnk_clr_r;          // clears the frame marker in reset
    logic [9:0]  cnt_r;              // rising edges in frame
    logic [9:0]  cnt_nxt;
    logic [7:0]  sh_r;               // input shift register
    logic [7:0]  opc_r;              // command code
    logic [23:0] addr_r;             // otp address
    logic [6:0]  nb_r;               // bytes latched
    logic        drive_r;            // output driving
    logic        out_r;              // output bit
    logic [15:0] st_l1_r;            // status into link, stage 1
    logic [15:0] st_l2_r;            // status into link, stage 2
    logic [15:0] st_w;               // {flag status, status}
    logic [9:0]  k;
    logic [7:0]  rloc;
    logic        cs_s1_r, cs_s2_r, cs_s3_r;
    logic        tg_s1_r, tg_s2_r, tg_used_r;
    logic        frame_end;
    sro_pkg::sro_state_t st_r, st_nxt;
    logic [23:0] tmr_r;
    logic        wip_r, wel_r, pec_r, esus_r, psus_r, pfail_r, prot_r;
    logic [25:0] sect_r, page_r;
    logic        is_wren, is_res, is_pg, res_go, pg_acc, pg_lock;
    logic        otp_end, done, blk_hit, lock_open;
    logic [7:0]  wloc [0:64];

    ////////////////////////////////////////////////////////////////////
    // link side, clocked by the host serial clock

    // preset while deselected so the first edge of a frame is known
    always_ff @(posedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in)
            start_r <= 1'b1;
        else
            start_r <= 1'b0;
    end

    assign cnt_nxt = start_r ? 10'h001 :
                     (cnt_r == sro_pkg::CNT_MAX) ? cnt_r : cnt_r + 10'h001;

    // bit count; holds still after the frame
    always_ff @(posedge sclk_in) begin
        cnt_r <= cnt_nxt;
    end

    // frame marker, cleared while the system side is in reset so it
    // starts equal to the system copy; chip select stays high then,
    // so the clear never releases next to a serial edge
    always_ff @(posedge sclk_in or posedge lnk_clr_r) begin
        if (lnk_clr_r)
            tog_r <= 1'b0;
        else if (start_r)
            tog_r <= ~tog_r;
    end

    // command and address sampled on rising edges
    always_ff @(posedge sclk_in) begin
        sh_r <= {sh_r[6:0], serial_in_line_in};
        if (cnt_nxt == sro_pkg::OPC_END)
            opc_r <= {sh_r[6:0], serial_in_line_in};
        if (cnt_nxt > sro_pkg::OPC_END && cnt_nxt <= sro_pkg::ADDR_END)
            addr_r <= {addr_r[22:0], serial_in_line_in};
    end

    // program data bytes, extra bytes past 65 are dropped
    always_ff @(posedge sclk_in) begin
        if (start_r) begin
            nb_r <= 7'h00;
        end else if (opc_r == sro_pkg::OP_PG_OTP &&
                     cnt_nxt > sro_pkg::ADDR_END &&
                     cnt_nxt[2:0] == 3'h0 &&
                     nb_r < sro_pkg::OTP_LATCH) begin
            buf_r[nb_r] <= {sh_r[6:0], serial_in_line_in};
            nb_r        <= nb_r + 7'h01;
        end
    end

    // status bits crossing into the link domain, bits polled singly
    always_ff @(posedge sclk_in) begin
        st_l1_r <= st_w;
        st_l2_r <= st_l1_r;
    end

    // read data position; the address sticks at the last location
    always_comb begin
        k    = cnt_r - sro_pkg::RD_DATA;
        rloc = loc_sum(addr_r, k[9:3]);
        if (rloc > {1'b0, sro_pkg::OTP_LAST})
            rloc = {1'b0, sro_pkg::OTP_LAST};
    end

    // otp array is read across domains; it only changes between
    // frames, so a read during a running program already sees the new data
    always_ff @(negedge sclk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            drive_r <= 1'b0;
            out_r   <= 1'b0;
        end else if (opc_r == sro_pkg::OP_RD_OTP &&
                     cnt_r >= sro_pkg::RD_DATA) begin
            drive_r <= 1'b1;
            out_r   <= otp_mem[rloc[6:0]][~k[2:0]];
        end else if (opc_r == sro_pkg::OP_RDSR &&
                     cnt_r >= sro_pkg::OPC_END) begin
            drive_r <= 1'b1;
            out_r   <= st_l2_r[~cnt_r[2:0]];
        end else if (opc_r == sro_pkg::OP_RDFSR &&
                     cnt_r >= sro_pkg::OPC_END) begin
            drive_r <= 1'b1;
            out_r   <= st_l2_r[{1'b1, ~cnt_r[2:0]}];
        end else begin
            drive_r <= 1'b0;
            out_r   <= 1'b0;
        end
    end

    // raw chip select also gates the enable so release is immediate
    assign serial_out_line_oe_out = drive_r & ~cs_n_in;
    assign serial_out_line_out    = out_r;

    ////////////////////////////////////////////////////////////////////
    // system side: frame end detection

    // registered reset image that clears the link frame marker
    always_ff @(posedge clock_in) begin
        lnk_clr_r <= ~rst_n_in;
    end

    // chip select and frame marker synchronisers
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cs_s1_r   <= 1'b1;
            cs_s2_r   <= 1'b1;
            cs_s3_r   <= 1'b1;
            tg_s1_r   <= 1'b0;
            tg_s2_r   <= 1'b0;
            tg_used_r <= 1'b0;
        end else begin
            cs_s1_r <= cs_n_in;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            tg_s1_r <= tog_r;
            tg_s2_r <= tg_s1_r;
            if (frame_end)
                tg_used_r <= tg_s2_r;
        end
    end

    // a select pulse without clocks repeats no old command
    assign frame_end = cs_s2_r & ~cs_s3_r & (tg_s2_r != tg_used_r);

    // command decode; link fields are still while the link clock stops
    always_comb begin
        is_wren = frame_end && opc_r == sro_pkg::OP_WREN &&
                  cnt_r == sro_pkg::OPC_END;
        is_res  = frame_end && opc_r == sro_pkg::OP_RESUME &&
                  cnt_r == sro_pkg::OPC_END;
        is_pg   = frame_end && opc_r == sro_pkg::OP_PG_OTP &&
                  cnt_r[2:0] == 3'h0 &&
                  cnt_r >= sro_pkg::RD_DATA;
        lock_open = otp_mem[sro_pkg::OTP_LAST][sro_pkg::LOCK_BIT];
        res_go  = is_res && (psus_r || esus_r) &&
                  st_r == sro_pkg::SRO_IDLE;
        pg_acc  = is_pg && wel_r && lock_open &&
                  st_r == sro_pkg::SRO_IDLE;
        pg_lock = is_pg && wel_r && !lock_open &&
                  st_r == sro_pkg::SRO_IDLE;
        otp_end = st_r == sro_pkg::SRO_OTP && tmr_r == 24'h000000;
        done    = st_r == sro_pkg::SRO_RESUMED && op_done_in;
        blk_hit = chk_prog_in && esus_r &&
                  same_sect(chk_addr_in, sect_r);
    end

    ////////////////////////////////////////////////////////////////////
    // system side: operation state and timer

    always_comb begin
        case (st_r)
            sro_pkg::SRO_IDLE:
                st_nxt = pg_acc ? sro_pkg::SRO_OTP :
                         res_go ? sro_pkg::SRO_RESUMED : sro_pkg::SRO_IDLE;
            sro_pkg::SRO_RESUMED:
                st_nxt = (done || pgm_suspend_in || ers_suspend_in) ?
                         sro_pkg::SRO_IDLE : sro_pkg::SRO_RESUMED;
            sro_pkg::SRO_OTP:
                st_nxt = otp_end ? sro_pkg::SRO_IDLE : sro_pkg::SRO_OTP;
            default:
                st_nxt = sro_pkg::SRO_IDLE;
        endcase
    end

    // busy and controller ready follow the state, so ready rises only
    // when the operation finishes or is suspended again
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            st_r  <= sro_pkg::SRO_IDLE;
            tmr_r <= 24'h000000;
            wip_r <= sro_pkg::SR_RST[sro_pkg::SR_WIP];
            pec_r <= sro_pkg::FSR_RST[sro_pkg::FSR_PEC];
        end else begin
            st_r  <= st_nxt;
            wip_r <= st_nxt != sro_pkg::SRO_IDLE;
            pec_r <= st_nxt == sro_pkg::SRO_IDLE;
            if (pg_acc)
                tmr_r <= PROG_LOAD;
            else if (st_r == sro_pkg::SRO_OTP && !otp_end)
                tmr_r <= tmr_r - 24'h000001;
        end
    end

    // resume pulses to the array engine; no lock recheck is asked for
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            resume_pgm_out <= 1'b0;
            resume_ers_out <= 1'b0;
        end else begin
            resume_pgm_out <= res_go && psus_r;
            resume_ers_out <= res_go && !psus_r;
        end
    end

    // suspend marks and recorded region; a new suspend beats a resume
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            psus_r <= sro_pkg::FSR_RST[sro_pkg::FSR_PSUS];
            esus_r <= sro_pkg::FSR_RST[sro_pkg::FSR_ESUS];
            sect_r <= 26'h0000000;
            page_r <= 26'h0000000;
        end else begin
            if (res_go && psus_r)
                psus_r <= 1'b0;
            if (res_go && !psus_r)
                esus_r <= 1'b0;
            if (pgm_suspend_in) begin
                psus_r <= 1'b1;
                page_r <= suspend_addr_in;
            end
            if (ers_suspend_in) begin
                esus_r <= 1'b1;
                sect_r <= suspend_addr_in;
            end
        end
    end

    // write enable latch; a refused or locked program leaves it set
    always_ff @(posedge clock_in) begin
        if (!rst_n_in)
            wel_r <= sro_pkg::SR_RST[sro_pkg::SR_WEL];
        else if (is_wren)
            wel_r <= 1'b1;
        else if (otp_end)
            wel_r <= 1'b0;
    end

    // error flags are sticky until reset; no clear command here
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pfail_r <= sro_pkg::FSR_RST[sro_pkg::FSR_PFAIL];
            prot_r  <= sro_pkg::FSR_RST[sro_pkg::FSR_PROT];
        end else begin
            if ((otp_end && otp_stuck_in) || pg_lock || blk_hit)
                pfail_r <= 1'b1;
            if (pg_lock)
                prot_r <= 1'b1;
        end
    end

    // access checks against the suspended page or sector
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            read_undef_out <= 1'b0;
            prog_block_out <= 1'b0;
        end else begin
            read_undef_out <= chk_read_in &&
                ((esus_r && same_sect(chk_addr_in, sect_r)) ||
                 (psus_r && chk_addr_in[25:sro_pkg::PAGE_LSB] ==
                            page_r[25:sro_pkg::PAGE_LSB]));
            prog_block_out <= blk_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // otp array; cells only go from 1 to 0, written while deselected

    always_comb begin
        for (int j = 0; j < 65; j++)
            wloc[j] = loc_sum(addr_r, 7'(j));
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            for (int j = 0; j < 65; j++)
                otp_mem[j] <= sro_pkg::OTP_ERASED;
        end else if (pg_acc) begin
            for (int j = 0; j < 65; j++) begin
                if (7'(j) < nb_r && wloc[j] <= {1'b0, sro_pkg::OTP_LAST})
                    otp_mem[wloc[j][6:0]] <=
                        otp_mem[wloc[j][6:0]] & buf_r[j];
            end
        end
    end

    // register images
    always_comb begin
        st_w = {sro_pkg::FSR_RST & 8'h00, sro_pkg::SR_RST};
        st_w[sro_pkg::SR_WIP]      = wip_r;
        st_w[sro_pkg::SR_WEL]      = wel_r;
        st_w[8 + sro_pkg::FSR_PROT]  = prot_r;
        st_w[8 + sro_pkg::FSR_PSUS]  = psus_r;
        st_w[8 + sro_pkg::FSR_PFAIL] = pfail_r;
        st_w[8 + sro_pkg::FSR_ESUS]  = esus_r;
        st_w[8 + sro_pkg::FSR_PEC]   = pec_r;
    end

    assign status_out      = st_w[7:0];
    assign flag_status_out = st_w[15:8];

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence res_idle_s;
        frame_end && opc_r == sro_pkg::OP_RESUME && !psus_r && !esus_r;
    endsequence
    sequence otp_nowel_s;
        is_pg && !wel_r && st_r == sro_pkg::SRO_IDLE;
    endsequence

    resume_ign_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) res_idle_s |=>
        !resume_pgm_out && !resume_ers_out)
        else $error("resume taken with nothing suspended");
    resume_busy_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) res_go |=>
        wip_r && !pec_r && (resume_pgm_out || resume_ers_out))
        else $error("resume did not set busy");
    done_ready_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) done && !pg_acc |=> pec_r && !wip_r)
        else $error("ready not restored after resume");
    nest_order_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) res_go && psus_r && esus_r &&
        !pgm_suspend_in |=> !psus_r && esus_r && resume_pgm_out)
        else $error("nested resume order wrong");
    otp_nowel_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) otp_nowel_s |=> !wip_r && $stable(prot_r))
        else $error("otp program ran without latch");
    otp_busy_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) pg_acc |=>
        wip_r && !pec_r && st_r == sro_pkg::SRO_OTP)
        else $error("otp program not busy");
    otp_end_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) otp_end && !is_wren |=>
        !wel_r && !wip_r && pec_r)
        else $error("otp end state wrong");
    otp_fail_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) otp_end && otp_stuck_in |=> pfail_r)
        else $error("otp timeout not flagged");
    lock_err_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) pg_lock |=>
        wel_r && prot_r && pfail_r && !wip_r)
        else $error("locked otp program not refused");
    prog_blk_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) blk_hit && !otp_end && !is_wren |=>
        prog_block_out && pfail_r && $stable(wel_r))
        else $error("program into suspended sector");
    read_undef_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) chk_read_in && esus_r &&
        same_sect(chk_addr_in, sect_r) |=> read_undef_out)
        else $error("suspended sector read not flagged");
    cs_release_a: assert property (@(posedge clock_in)
        disable iff (!rst_n_in) cs_n_in |->
        !drive_r && !serial_out_line_oe_out)
        else $error("output driven while deselected");
endmodule : sro_ctrl
`default_nettype wire

// *** bench/sro_host.sv ***
// Purpose: host serial controller model that drives sro_ctrl frames
// Assumes: serial clock period 125 ns, idle low, runs only in frames
// Notes:   the data line shows the inverse of its last bit between frames
`timescale 1ns/10ps
`default_nettype none
module sro_host (
    output logic      sclk_out,  // serial clock
    output logic      cs_n_out,  // chip select, low
    output logic      mosi_out,  // host to device
    input  wire logic miso_in    // device to host
);
    // one frame: nb bits msb first, rx gathers bits on rising edges
    task automatic xfer(input logic [103:0] tx, input int nb,
                        output logic [31:0] rx);
        rx = '0;
        cs_n_out = 1'b0;
        for (int i = 0; i < nb; i++) begin
            mosi_out = tx[nb-1-i];
            #62.5 sclk_out = 1'b1;
            rx = {rx[30:0], miso_in};
            #62.5 sclk_out = 1'b0;
        end
        // rises right after bit nb, whole bytes or not, so it may end any read early
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
        #100;
    endtask : xfer
    // idle levels before the first frame
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
    end
endmodule : sro_host
`default_nettype wire

// *** bench/tb_sro_ctrl.sv ***
// Purpose: self-checking bench for sro_ctrl
// Assumes: otp program time cut to 100 system clocks
// Notes:   frames come from the host model in its own clock domain
`timescale 1ns/10ps
`default_nettype none
module tb_sro_ctrl;
    logic        clock_in, rst_n_in, sclk, cs_n, mosi, miso, oe;
    logic        p_sus, e_sus, done, c_rd, c_pg, undef, blk, r_p, r_e;
    logic        stuck;
    logic [25:0] s_addr, c_addr;
    logic [7:0]  sr, fsr;
    logic [31:0] rx;
    int          n_mismatch, check_count, n_rp, n_re;
    sro_ctrl #(.OTP_PROG_TIME_US(1)) i_sro_ctrl (.clock_in(clock_in),
        .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .serial_in_line_in(mosi), .serial_out_line_out(miso),
        .serial_out_line_oe_out(oe), .pgm_suspend_in(p_sus),
        .ers_suspend_in(e_sus), .suspend_addr_in(s_addr),
        .op_done_in(done), .resume_pgm_out(r_p), .resume_ers_out(r_e),
        .chk_read_in(c_rd), .chk_prog_in(c_pg), .chk_addr_in(c_addr),
        .read_undef_out(undef), .prog_block_out(blk),
        .otp_stuck_in(stuck), .status_out(sr), .flag_status_out(fsr));
    sro_host i_sro_host (.sclk_out(sclk), .cs_n_out(cs_n),
        .mosi_out(mosi), .miso_in(miso));
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // resume pulses stand one cycle, so tally them at every edge
    always @(posedge clock_in) begin
        if (r_p === 1'b1) n_rp++;
        if (r_e === 1'b1) n_re++;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one-cycle pulse after an idle cycle; returns at the falling edge
    // where the one-cycle check answer stands
    task automatic pulse(ref logic s, input logic [25:0] a);
        @(negedge clock_in);
        s_addr = a;
        c_addr = a;
        s = 1'b1;
        @(negedge clock_in);
        s = 1'b0;
    endtask : pulse
    task automatic cmd(input logic [103:0] tx, input int nb);
        i_sro_host.xfer(tx, nb, rx);
        repeat (6) @(negedge clock_in);
    endtask : cmd
    // reset held five clocks, chip select idle high meanwhile
    task automatic reset_dut;
        rst_n_in = 1'b0;
        repeat (5) @(negedge clock_in);
        rst_n_in = 1'b1;
        repeat (3) @(negedge clock_in);
    endtask : reset_dut
    task automatic t_resume_idle;
        cmd(8'h7a, 8);
        chk(sr, 8'h00);
        chk(fsr, 8'h80);
        chk(n_rp + n_re, 0);
    endtask : t_resume_idle
    task automatic t_resume_pgm;
        pulse(p_sus, 26'h0123456);
        chk(fsr, 8'h84);
        cmd(8'h7a, 8);
        chk(sr, 8'h01);
        chk(fsr, 8'h00);
        chk(n_rp, 1);
        pulse(done, 26'h0);
        chk(sr, 8'h00);
        chk(fsr, 8'h80);
    endtask : t_resume_pgm
    task automatic t_otp;
        cmd({8'h42, 24'h00003e, 8'ha5}, 40);
        chk(sr, 8'h00);
        cmd(8'h06, 8);
        cmd({8'h42, 24'h00003e, 24'ha55a3c}, 56);
        chk(sr, 8'h03);
        chk(fsr, 8'h00);
        for (int k = 0; k < 300 && sr[0] !== 1'b0; k++)
            @(negedge clock_in);
        chk(sr, 8'h00);
        chk(fsr, 8'h80);
        cmd({8'h4b, 24'h00003e, 8'h00, 32'h00000000}, 72);
        chk(rx, 32'ha55a3c3c);
        chk(oe, 1'b0);
        cmd(8'h06, 8);
        cmd({8'h42, 24'h000000, 8'h00}, 40);
        chk(sr, 8'h02);
        chk(fsr, 8'h92);
    endtask : t_otp
    task automatic t_nested;
        // mid-run reset clears the sticky flags left by earlier tests
        reset_dut();
        pulse(e_sus, 26'h00a1234);
        pulse(p_sus, 26'h00b5600);
        chk(fsr, 8'hc4);
        pulse(c_rd, 26'h00affff);
        chk(undef, 1'b1);
        pulse(c_rd, 26'h00b5611);
        chk(undef, 1'b1);
        pulse(c_rd, 26'h00b5711);
        chk(undef, 1'b0);
        pulse(c_pg, 26'h00a0000);
        chk(blk, 1'b1);
        cmd(8'h7a, 8);
        chk(fsr, 8'h50);
        pulse(done, 26'h0);
        cmd(8'h7a, 8);
        chk(n_re, 1);
        chk(fsr, 8'h10);
    endtask : t_nested
    // a program ending in a partial byte is ignored, then a program that times out
    task automatic t_timeout;
        reset_dut();
        cmd(8'h06, 8);
        cmd({8'h42, 24'h00003e, 8'ha5, 4'h0}, 44);
        chk(sr, 8'h02);
        chk(fsr, 8'h80);
        stuck = 1'b1;
        cmd({8'h42, 24'h000000, 8'hff}, 40);
        chk(sr, 8'h03);
        for (int k = 0; k < 300 && sr[0] !== 1'b0; k++)
            @(negedge clock_in);
        stuck = 1'b0;
        chk(sr, 8'h00);
        chk(fsr, 8'h90);
    endtask : t_timeout
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial begin
        {p_sus, e_sus, done, c_rd, c_pg, stuck} = '0;
        s_addr = '0;
        c_addr = '0;
        reset_dut();
        t_resume_idle();
        t_resume_pgm();
        t_otp();
        t_timeout();
        t_nested();
        tally_and_finish();
    end
    // the whole run needs some 50 us of frames
    initial begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb_sro_ctrl
`default_nettype wire
